/* File: ccrb_bank.sv */
// Charger configuration register bank with watchdog and derived settings
`timescale 1ns/100ps
// What this block does
// - Input current limit 6 bits, reset 500mA
// - Apply lower of register and enabled pin
// - Detection done loads limit from select pin
// - Voltage offset 5 bits, reset 600mV
// - Double offset above 6V, clamp threshold
// - Conversion start busy-high, read-only when continuous
// - Force detect self-clears after detection
// - Auto detect at plug-in when enabled
// - Watchdog restart self-clears after reset
// - Charge enable resets 1, load resets 0
// - Minimum system voltage 3 bits, reset 3.5V
// - Fast charge current clamped, zero disables
// - Pulse control enable resets 0
// - Pre-charge current 4 bits, reset 128mA
// - Termination current, applied when enabled
// - Charge voltage clamped at 110000
// - Pre-charge exit and recharge offset bits
// - Watchdog period decode, 00 disables
// - Safety timer enable and period
// - Cold current ratio bit
// - IR compensation fields reset zero
// - Thermal threshold reset 120C
// - Watchdog expiry resets all but limit and offset
// - Any write enters host mode
module ccrb_bank
   import ccrb_pkg::*;
#(
   parameter int WD_UNIT_CYCLES = CCRB_CLK_HZ
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic reg_reset,
   input wire logic limit_pin_valid,
   input wire logic [5:0] limit_pin,
   input wire logic source_select,
   input wire logic vbus_plug,
   input wire logic detect_done,
   input wire logic adc_busy,
   input wire logic vbus_above_6v,
   output logic [7:0] rdata,
   output logic addr_ack,
   output logic host_mode,
   output logic watchdog_fault,
   output logic detect_start,
   output logic conversion_start,
   output logic conversion_rate,
   output logic [5:0] input_current_limit,
   output logic [7:0] input_voltage_threshold,
   output logic charge_active,
   output logic battery_load_enable,
   output logic pulse_control_enable,
   output logic [6:0] fast_charge_current,
   output logic termination_enable,
   output logic safety_timer_enable,
   output logic [5:0] charge_voltage
);
   localparam int WD_W = 40;
   localparam logic [WD_W-1:0] WD_C1 = WD_W'(longint'(CCRB_WD_S1) * WD_UNIT_CYCLES);
   localparam logic [WD_W-1:0] WD_C2 = WD_W'(longint'(CCRB_WD_S2) * WD_UNIT_CYCLES);
   localparam logic [WD_W-1:0] WD_C3 = WD_W'(longint'(CCRB_WD_S3) * WD_UNIT_CYCLES);

   logic [7:0] r_src, r_vos, r_conv, r_sys, r_fast_charge_current, r_pre, r_charge_voltage, r_tmr, r_comp;
   logic [WD_W-1:0] wd_count;
   logic vbus_plug_d;
   logic detect_run;

   // ****************************************
   // Decode
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   wire wr_src = wr_en && hit(addr, CCRB_OFS_SRC);
   wire wr_vos = wr_en && hit(addr, CCRB_OFS_VOS);
   wire wr_conv = wr_en && hit(addr, CCRB_OFS_CONV);
   wire wr_sys = wr_en && hit(addr, CCRB_OFS_SYS);
   wire wr_fast_charge_current = wr_en && hit(addr, CCRB_OFS_FAST_CHARGE_CURRENT);
   wire wr_pre = wr_en && hit(addr, CCRB_OFS_PRE);
   wire wr_charge_voltage = wr_en && hit(addr, CCRB_OFS_CHARGE_VOLTAGE);
   wire wr_tmr = wr_en && hit(addr, CCRB_OFS_TMR);
   wire wr_comp = wr_en && hit(addr, CCRB_OFS_COMP);
   wire addr_ok = (addr <= CCRB_OFS_LAST);

   wire [1:0] wd_sel = r_tmr[5:4];
   wire [WD_W-1:0] wd_limit = (wd_sel == 2'b01) ? WD_C1 :
                              (wd_sel == 2'b10) ? WD_C2 : WD_C3;
   wire wd_on = (wd_sel != 2'b00);
   wire wd_kick = wr_sys && wdata[CCRB_B_WDRST];
   wire wd_expire = wd_on && host_mode && (wd_count >= wd_limit - WD_W'(1)) && !wd_kick;
   // Register reset restores everything; watchdog spares limit and offset
   wire soft_clr = wd_expire || reg_reset;
   wire plug_edge = vbus_plug && !vbus_plug_d;
   wire detect_req = (plug_edge && r_conv[CCRB_B_AUTO]) ||
                     (wr_conv && wdata[CCRB_B_FORCE]);
   wire rate_now = wr_conv ? wdata[CCRB_B_CRATE] : r_conv[CCRB_B_CRATE];
   // Start bit held by hardware while busy, ignores writes while continuous
   // Not fed back from itself, so a finished detection cannot leave it stuck high
   wire cstart_sw = (!r_conv[CCRB_B_CRATE] && wr_conv) ? wdata[CCRB_B_CSTART] : 1'b0;
   wire cstart_next = cstart_sw || adc_busy || detect_run || detect_req;
   wire [5:0] limit_pin_det = source_select ? CCRB_LIMIT_PIN_HI : CCRB_LIMIT_PIN_LO;

   wire [7:0] next_src = (wr_src ? wdata : r_src) & CCRB_MSK_SRC;
   wire [7:0] next_conv_w = ((wr_conv ? wdata : r_conv) & CCRB_MSK_CONV) & ~8'h80;
   wire [7:0] next_conv = next_conv_w | {cstart_next, 7'h00};
   wire [7:0] next_sys = (wr_sys ? (wdata & ~8'h40) : r_sys) & CCRB_MSK_SYS;

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (!rstn || reg_reset)
      begin
         r_src <= CCRB_RST_SRC;
         r_vos <= CCRB_RST_VOS;
      end
      else
      begin
         if (detect_run && detect_done)
            r_src <= {next_src[7:6], limit_pin_det};
         else if (wd_expire)
            r_src <= {CCRB_RST_SRC[7:6], r_src[5:0]};
         else
            r_src <= next_src;
         if (wr_vos && !wd_expire)
            r_vos <= wdata & CCRB_MSK_VOS;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn || soft_clr)
      begin
         r_conv <= CCRB_RST_CONV;
         r_sys <= CCRB_RST_SYS;
         r_fast_charge_current <= CCRB_RST_FAST_CHARGE_CURRENT;
         r_pre <= CCRB_RST_PRE;
         r_charge_voltage <= CCRB_RST_CHARGE_VOLTAGE;
         r_tmr <= CCRB_RST_TMR;
         r_comp <= CCRB_RST_COMP;
      end
      else
      begin
         r_conv <= (detect_run && detect_done) ? (next_conv & ~8'h02) : next_conv;
         r_sys <= next_sys;
         if (wr_fast_charge_current)
            r_fast_charge_current <= wdata;
         if (wr_pre)
            r_pre <= wdata;
         if (wr_charge_voltage)
            r_charge_voltage <= wdata;
         if (wr_tmr)
            r_tmr <= wdata & CCRB_MSK_TMR;
         if (wr_comp)
            r_comp <= wdata;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         host_mode <= 1'b0;
         wd_count <= '0;
         vbus_plug_d <= 1'b0;
         detect_run <= 1'b0;
         detect_start <= 1'b0;
      end
      else
      begin
         host_mode <= wr_en ? 1'b1 : (soft_clr ? 1'b0 : host_mode);
         wd_count <= (wd_kick || wr_en || !host_mode || !wd_on) ? '0 : wd_count + WD_W'(1);
         vbus_plug_d <= vbus_plug;
         detect_run <= detect_req ? 1'b1 : (detect_done ? 1'b0 : detect_run);
         detect_start <= detect_req;
      end
   end

   // ****************************************
   // Read path and derived outputs
   // ****************************************
   wire [7:0] rd_mux = !addr_ok ? 8'h00 :
      (addr == CCRB_OFS_SRC) ? r_src : (addr == CCRB_OFS_VOS) ? r_vos :
      (addr == CCRB_OFS_CONV) ? r_conv : (addr == CCRB_OFS_SYS) ? r_sys :
      (addr == CCRB_OFS_FAST_CHARGE_CURRENT) ? r_fast_charge_current : (addr == CCRB_OFS_PRE) ? r_pre :
      (addr == CCRB_OFS_CHARGE_VOLTAGE) ? r_charge_voltage : (addr == CCRB_OFS_TMR) ? r_tmr : r_comp;

   // Lower of register and pin, pin counted only when enabled
   wire [5:0] limit_pin_eff = (r_src[CCRB_B_LIMEN] && limit_pin_valid && limit_pin < r_src[5:0]) ?
                         limit_pin : r_src[5:0];
   // Threshold uses offset, doubled above 6V, within clamp
   wire [7:0] vos_eff = vbus_above_6v ? {2'b00, r_vos[4:0], 1'b0} : {3'b000, r_vos[4:0]};
   wire [7:0] vin_raw = CCRB_VIN_MIN + vos_eff;
   wire [7:0] vin_cl = (vin_raw > CCRB_VIN_MAX) ? CCRB_VIN_MAX : vin_raw;
   wire [6:0] fast_charge_current_cl = (r_fast_charge_current[6:0] > CCRB_FAST_CHARGE_CURRENT_MAX) ? CCRB_FAST_CHARGE_CURRENT_MAX : r_fast_charge_current[6:0];
   wire [5:0] charge_voltage_cl = (r_charge_voltage[7:2] > CCRB_CHARGE_VOLTAGE_MAX) ? CCRB_CHARGE_VOLTAGE_MAX : r_charge_voltage[7:2];

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         rdata <= 8'h00;
         addr_ack <= 1'b0;
         watchdog_fault <= 1'b1;
         conversion_start <= 1'b0;
         conversion_rate <= 1'b0;
         input_current_limit <= CCRB_RST_SRC[5:0];
         input_voltage_threshold <= CCRB_VIN_MIN;
         charge_active <= 1'b0;
         battery_load_enable <= 1'b0;
         pulse_control_enable <= 1'b0;
         fast_charge_current <= CCRB_RST_FAST_CHARGE_CURRENT[6:0];
         termination_enable <= 1'b1;
         safety_timer_enable <= 1'b1;
         charge_voltage <= CCRB_RST_CHARGE_VOLTAGE[7:2];
      end
      else
      begin
         rdata <= rd_en ? rd_mux : rdata;
         addr_ack <= (rd_en || wr_en) && addr_ok;
         watchdog_fault <= !host_mode;
         conversion_start <= r_conv[CCRB_B_CSTART];
         conversion_rate <= r_conv[CCRB_B_CRATE];
         input_current_limit <= limit_pin_eff;
         input_voltage_threshold <= vin_cl;
         charge_active <= r_sys[CCRB_B_CHGEN] && (fast_charge_current_cl != 7'h00);
         battery_load_enable <= r_sys[CCRB_B_BLOAD];
         pulse_control_enable <= r_fast_charge_current[CCRB_B_PULSE];
         fast_charge_current <= fast_charge_current_cl;
         termination_enable <= r_tmr[CCRB_B_TERM];
         safety_timer_enable <= r_tmr[CCRB_B_TMREN];
         charge_voltage <= charge_voltage_cl;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_wdrst_clear;
      @(posedge mclk) disable iff (!rstn) wd_kick |=> !r_sys[CCRB_B_WDRST];
   endproperty
   a_wdrst_clear: assert property (p_wdrst_clear) else $error("watchdog restart not cleared");

   property p_host_on_write;
      @(posedge mclk) disable iff (!rstn) (wr_en && !reg_reset) |=> host_mode ##1 !watchdog_fault;
   endproperty
   a_host_on_write: assert property (p_host_on_write) else $error("write did not enter host mode");

   property p_wd_keeps_limit;
      @(posedge mclk) disable iff (!rstn)
         (wd_expire && !reg_reset && !detect_done) |=> r_src[5:0] == $past(r_src[5:0]);
   endproperty
   a_wd_keeps_limit: assert property (p_wd_keeps_limit) else $error("limit lost at expiry");

   property p_fast_charge_current_clamp;
      @(posedge mclk) disable iff (!rstn) fast_charge_current <= CCRB_FAST_CHARGE_CURRENT_MAX;
   endproperty
   a_fast_charge_current_clamp: assert property (p_fast_charge_current_clamp) else $error("charge current above clamp");

   property p_charge_voltage_clamp;
      @(posedge mclk) disable iff (!rstn) charge_voltage <= CCRB_CHARGE_VOLTAGE_MAX;
   endproperty
   a_charge_voltage_clamp: assert property (p_charge_voltage_clamp) else $error("charge voltage above clamp");

   property p_vin_range;
      @(posedge mclk) disable iff (!rstn)
         input_voltage_threshold >= CCRB_VIN_MIN && input_voltage_threshold <= CCRB_VIN_MAX;
   endproperty
   a_vin_range: assert property (p_vin_range) else $error("threshold out of range");

   property p_busy_start;
      @(posedge mclk) disable iff (!rstn) (adc_busy && !soft_clr) |=> r_conv[CCRB_B_CSTART];
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("start bit low while busy");

   property p_reserved_zero;
      @(posedge mclk) disable iff (!rstn)
         (r_vos[7:5] == 3'b000) && (r_conv[5] == 1'b0) && (r_sys[5] == 1'b0) && !r_sys[0];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_detect_load;
      @(posedge mclk) disable iff (!rstn)
         (detect_run && detect_done && !reg_reset) |=> r_src[5:0] == $past(limit_pin_det);
   endproperty
   a_detect_load: assert property (p_detect_load) else $error("detect did not load limit");
endmodule

/* File: ccrb_bank_tb.sv */
// Self-checking testbench of the charger configuration register bank
`timescale 1ns/100ps
module ccrb_bank_tb
   import ccrb_pkg::*;
;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic wr_en, rd_en, reg_reset, limit_pin_valid, source_select, vbus_plug;
   logic detect_done, adc_busy, vbus_above_6v, addr_ack, host_mode, watchdog_fault;
   logic detect_start, conversion_start, conversion_rate, charge_active;
   logic battery_load_enable, pulse_control_enable, termination_enable, safety_timer_enable;
   logic [7:0] addr, wdata, rdata, input_voltage_threshold;
   logic [5:0] limit_pin, input_current_limit, charge_voltage;
   logic [6:0] fast_charge_current;
   int fail_count = 0;
   int compares = 0;
   localparam logic [7:0] RST_TAB [9] = '{CCRB_RST_SRC, CCRB_RST_VOS, CCRB_RST_CONV,
      CCRB_RST_SYS, CCRB_RST_FAST_CHARGE_CURRENT, CCRB_RST_PRE, CCRB_RST_CHARGE_VOLTAGE, CCRB_RST_TMR, CCRB_RST_COMP};

   always #50 mclk = ~mclk;

   // Ten cycles per second keeps the 40 s watchdog at 400 cycles
   ccrb_bank #(.WD_UNIT_CYCLES(10)) i_ccrb_bank (.mclk(mclk), .rstn(rstn), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wdata(wdata), .reg_reset(reg_reset),
      .limit_pin_valid(limit_pin_valid), .limit_pin(limit_pin), .source_select(source_select),
      .vbus_plug(vbus_plug), .detect_done(detect_done), .adc_busy(adc_busy),
      .vbus_above_6v(vbus_above_6v), .rdata(rdata), .addr_ack(addr_ack),
      .host_mode(host_mode), .watchdog_fault(watchdog_fault), .detect_start(detect_start),
      .conversion_start(conversion_start), .conversion_rate(conversion_rate),
      .input_current_limit(input_current_limit),
      .input_voltage_threshold(input_voltage_threshold), .charge_active(charge_active),
      .battery_load_enable(battery_load_enable), .pulse_control_enable(pulse_control_enable),
      .fast_charge_current(fast_charge_current), .termination_enable(termination_enable),
      .safety_timer_enable(safety_timer_enable), .charge_voltage(charge_voltage));

   ccrb_host i_ccrb_host (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata(rdata), .addr_ack(addr_ack));

   task automatic report_and_stop();
      $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_ccrb_host.write(a, d);
   endtask

   // Mapped offsets acknowledge, others stay silent
   task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic k;
      i_ccrb_host.read(a, d, k);
      chk(n, e, d);
      chk("addr_ack", {7'h00, a <= CCRB_OFS_LAST}, {7'h00, k});
   endtask

   // Watches a few cycles for a detection launch
   task automatic detect(input string n, input logic e);
      logic seen;
      seen = 1'b0;
      repeat (4)
      begin
         seen = seen | (detect_start === 1'b1);
         tick(1);
      end
      chk(n, {7'h00, e}, {7'h00, seen});
   endtask

   task automatic finish_detect();
      @(posedge mclk);
      detect_done <= 1'b1;
      @(posedge mclk);
      detect_done <= 1'b0;
      tick(2);
   endtask

   initial
   begin
      {reg_reset, limit_pin_valid, source_select, vbus_plug} = 4'h0;
      {detect_done, adc_busy, vbus_above_6v} = 3'h0;
      limit_pin = 6'h00;
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      tick(1);
      chk("wd_fault", {7'h00, watchdog_fault}, 8'h01);
      for (int i = 0; i < 9; i++)
         rdchk("reset", i[7:0], RST_TAB[i]);
      rdchk("unmapped", 8'h09, 8'h00);
      $display("test reset done");
      wr(8'h00, 8'hFF);
      wr(8'h01, 8'hFF);
      wr(8'h05, 8'hFF);
      wr(8'h07, 8'hFF);
      wr(8'h08, 8'hFF);
      rdchk("reserved00", 8'h00, 8'h7F);
      rdchk("reserved01", 8'h01, 8'h1F);
      rdchk("fields05", 8'h05, 8'hFF);
      rdchk("reserved07", 8'h07, 8'hBF);
      rdchk("fields08", 8'h08, 8'hFF);
      wr(8'h07, 8'h06);
      tick(2);
      chk("term_off", {7'h00, termination_enable}, 8'h00);
      chk("timer_off", {7'h00, safety_timer_enable}, 8'h00);
      chk("host_mode", {7'h00, host_mode}, 8'h01);
      chk("limit_pin", {2'b00, input_current_limit}, 8'h3F);
      limit_pin_valid <= 1'b1;
      limit_pin <= 6'h10;
      tick(3);
      chk("limit_pin_pin", {2'b00, input_current_limit}, 8'h10);
      chk("vin_low", input_voltage_threshold, 8'h2C);
      vbus_above_6v <= 1'b1;
      tick(3);
      chk("vin_high", input_voltage_threshold, 8'h4B);
      wr(8'h04, 8'hFF);
      wr(8'h06, 8'hFF);
      tick(2);
      chk("fast_charge_current_clamp", {1'b0, fast_charge_current}, 8'h4F);
      chk("charge_voltage_clamp", {2'b00, charge_voltage}, 8'h30);
      chk("pulse", {7'h00, pulse_control_enable}, 8'h01);
      wr(8'h04, 8'h00);
      wr(8'h03, 8'h50);
      tick(2);
      chk("chg_zero", {7'h00, charge_active}, 8'h00);
      rdchk("wd_restart", 8'h03, 8'h10);
      wr(8'h03, 8'h80);
      tick(2);
      chk("batload", {7'h00, battery_load_enable}, 8'h01);
      $display("test fields done");
      source_select <= 1'b1;
      wr(8'h02, 8'h02);
      detect("force", 1'b1);
      chk("conv_detect", {7'h00, conversion_start}, 8'h01);
      finish_detect();
      rdchk("force_clear", 8'h02, 8'h00);
      rdchk("psel_hi", 8'h00, 8'h48);
      source_select <= 1'b0;
      wr(8'h02, 8'h03);
      finish_detect();
      rdchk("psel_lo", 8'h00, 8'h7F);
      wr(8'h02, 8'h00);
      tick(2);
      vbus_plug <= 1'b1;
      detect("plug_off", 1'b0);
      vbus_plug <= 1'b0;
      wr(8'h02, 8'h01);
      vbus_plug <= 1'b1;
      detect("plug_on", 1'b1);
      finish_detect();
      wr(8'h02, 8'h40);
      wr(8'h02, 8'hC0);
      rdchk("conv_ro", 8'h02, 8'h40);
      adc_busy <= 1'b1;
      tick(3);
      chk("conv_busy", {7'h00, conversion_start}, 8'h01);
      chk("conversion_rate", {7'h00, conversion_rate}, 8'h01);
      adc_busy <= 1'b0;
      $display("test detection done");
      wr(8'h07, 8'h8D);
      tick(500);
      chk("wd_off", {7'h00, host_mode}, 8'h01);
      wr(8'h07, 8'h9D);
      wr(8'h04, 8'h00);
      tick(300);
      wr(8'h03, 8'h50);
      tick(300);
      chk("wd_serviced", {7'h00, host_mode}, 8'h01);
      tick(200);
      chk("wd_expired", {7'h00, watchdog_fault}, 8'h01);
      rdchk("wd_04", 8'h04, CCRB_RST_FAST_CHARGE_CURRENT);
      rdchk("wd_00", 8'h00, 8'h7F);
      rdchk("wd_01", 8'h01, 8'h1F);
      @(posedge mclk);
      reg_reset <= 1'b1;
      @(posedge mclk);
      reg_reset <= 1'b0;
      tick(2);
      rdchk("rr_00", 8'h00, CCRB_RST_SRC);
      rdchk("rr_01", 8'h01, CCRB_RST_VOS);
      $display("test watchdog done");
      report_and_stop();
   end

   // Tests take about 1500 cycles
   initial
   begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      report_and_stop();
   end
endmodule

/* File: ccrb_host.sv */
// Host model issuing single-byte register accesses to the bank
`timescale 1ns/100ps
module ccrb_host
(
   input wire logic mclk,
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic addr_ack
);
   initial
   begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
   end

   // Every write also services the watchdog
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
      #1;
   endtask

   // Answer lands on the strobe edge; sampled after it settles
   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ack);
      @(posedge mclk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
      ack = addr_ack;
   endtask
endmodule

/* File: ccrb_pkg.sv */
// Package: register map, field layout and reset values of the charger configuration bank
package ccrb_pkg;
   localparam logic [7:0] CCRB_OFS_SRC = 8'h00;
   localparam logic [7:0] CCRB_OFS_VOS = 8'h01;
   localparam logic [7:0] CCRB_OFS_CONV = 8'h02;
   localparam logic [7:0] CCRB_OFS_SYS = 8'h03;
   localparam logic [7:0] CCRB_OFS_FAST_CHARGE_CURRENT = 8'h04;
   localparam logic [7:0] CCRB_OFS_PRE = 8'h05;
   localparam logic [7:0] CCRB_OFS_CHARGE_VOLTAGE = 8'h06;
   localparam logic [7:0] CCRB_OFS_TMR = 8'h07;
   localparam logic [7:0] CCRB_OFS_COMP = 8'h08;
   localparam logic [7:0] CCRB_OFS_LAST = 8'h08;
   // Writable masks; reserved positions read zero
   localparam logic [7:0] CCRB_MSK_SRC = 8'h7F;
   localparam logic [7:0] CCRB_MSK_VOS = 8'h1F;
   localparam logic [7:0] CCRB_MSK_CONV = 8'hD3;
   localparam logic [7:0] CCRB_MSK_SYS = 8'hDE;
   localparam logic [7:0] CCRB_MSK_TMR = 8'hBF;
   localparam logic [7:0] CCRB_MSK_FULL = 8'hFF;
   // Reset values
   localparam logic [7:0] CCRB_RST_SRC = 8'h48;
   localparam logic [7:0] CCRB_RST_VOS = 8'h06;
   localparam logic [7:0] CCRB_RST_CONV = 8'h01;
   localparam logic [7:0] CCRB_RST_SYS = 8'h1A;
   localparam logic [7:0] CCRB_RST_FAST_CHARGE_CURRENT = 8'h20;
   localparam logic [7:0] CCRB_RST_PRE = 8'h13;
   localparam logic [7:0] CCRB_RST_CHARGE_VOLTAGE = 8'h5E;
   localparam logic [7:0] CCRB_RST_TMR = 8'h9D;
   localparam logic [7:0] CCRB_RST_COMP = 8'h03;
   // Field positions
   localparam int CCRB_B_LIMEN = 6;
   localparam int CCRB_B_CSTART = 7;
   localparam int CCRB_B_CRATE = 6;
   localparam int CCRB_B_FORCE = 1;
   localparam int CCRB_B_AUTO = 0;
   localparam int CCRB_B_BLOAD = 7;
   localparam int CCRB_B_WDRST = 6;
   localparam int CCRB_B_CHGEN = 4;
   localparam int CCRB_B_PULSE = 7;
   localparam int CCRB_B_TERM = 7;
   localparam int CCRB_B_TMREN = 3;
   localparam int CCRB_B_COLD = 0;
   localparam int CCRB_B_PEXIT = 1;
   localparam int CCRB_B_RECHG = 0;
   localparam logic [6:0] CCRB_FAST_CHARGE_CURRENT_MAX = 7'h4F;
   localparam logic [5:0] CCRB_CHARGE_VOLTAGE_MAX = 6'h30;
   localparam logic [5:0] CCRB_LIMIT_PIN_HI = 6'h08;
   localparam logic [5:0] CCRB_LIMIT_PIN_LO = 6'h3F;
   // Input voltage threshold codes, 100 mV per step above 2.6 V
   localparam logic [7:0] CCRB_VIN_MIN = 8'h0D;
   localparam logic [7:0] CCRB_VIN_MAX = 8'h7F;
   // Watchdog periods in seconds
   localparam int CCRB_WD_S1 = 40;
   localparam int CCRB_WD_S2 = 80;
   localparam int CCRB_WD_S3 = 160;
   localparam int CCRB_CLK_HZ = 10_000_000;
endpackage
